// file: verilog/fes_pkg.sv
// package for the flash erase, suspend and blank-check sequencer
// Function
// RQ1 - erase is setup 0020h, confirm 00D0h
// RQ2 - erased block reads back all FFFFh
// RQ3 - one erase; none under program suspend
// RQ4 - locked block or bad supply aborts erase
// RQ5 - erase setup switches partition to status
// RQ6 - erase order: precondition, erase, verify
// RQ7 - status bit 0 flags other-partition operation
// RQ8 - ready bit 7 low while erasing
// RQ9 - array reads of erasing partition undefined
// RQ10 - reset aborts running erase
// RQ11 - during erase only suspend accepted; the code also accepts read status
// RQ12 - suspend 00B0h halts after latency
// RQ13 - suspend shown in bits 7, 6, 2
// RQ14 - lock, supply or protect change aborts suspended
// RQ15 - program in erase-suspended block fails, bit 4
// RQ16 - suspend accepts only listed commands
// RQ17 - reset aborts suspended operations
// RQ18 - non-confirm to buffer block cancels fill
// RQ19 - resume 00D0h continues, clears suspend bit
// RQ20 - dual suspend resumes program first
// RQ21 - blank check 00BCh, 00D0h, refused suspended
// RQ22 - blank failure sets bits 7, 5
package fes_pkg;
  localparam int DATA_W = 16;
  localparam int BLK_W = 5;
  localparam int PART_W = 3;
  localparam int OFF_W = 7;
  localparam int ADDR_W = BLK_W + OFF_W;

  // command codes
  localparam logic [15:0] CMD_ERASE = 16'h0020;
  localparam logic [15:0] CMD_CONFIRM = 16'h00d0;
  localparam logic [15:0] CMD_SUSPEND = 16'h00b0;
  localparam logic [15:0] CMD_BLANK = 16'h00bc;
  localparam logic [15:0] CMD_RD_ARRAY = 16'h00ff;
  localparam logic [15:0] CMD_RD_STATUS = 16'h0070;
  localparam logic [15:0] CMD_CLR_STATUS = 16'h0050;
  localparam logic [15:0] CMD_RD_ID = 16'h0090;
  localparam logic [15:0] CMD_QUERY = 16'h0098;
  localparam logic [15:0] CMD_WORD_PROG = 16'h0040;
  localparam logic [15:0] CMD_BUF_PROG = 16'h00e8;
  localparam logic [15:0] CMD_EFP = 16'h0080;

  // operation_status_word bit positions
  localparam int SB_READY = 7;
  localparam int SB_ERS_SUSP = 6;
  localparam int SB_ERS_ERR = 5;
  localparam int SB_PRG_ERR = 4;
  localparam int SB_VPP_ERR = 3;
  localparam int SB_PRG_SUSP = 2;
  localparam int SB_LOCK_ERR = 1;
  localparam int SB_OTHER_PART = 0;

  localparam logic [15:0] ERASED_WORD = 16'hffff;
  localparam logic [15:0] UNDEF_WORD = 16'h0000;
  // identifier word, value arbitrary
  localparam logic [15:0] ID_WORD = 16'h5a01;

  // suspend_latency in microseconds and in clock cycles
  localparam int CLK_MHZ = 10;
  localparam int SUSP_LAT_US = 20;
  localparam int SUSP_CYC = SUSP_LAT_US * CLK_MHZ;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } fes_req_t;

  typedef enum logic [1:0] {RM_ARRAY, RM_STATUS, RM_ID} fes_rmode_t;
  typedef enum logic [2:0] {
    AR_IDLE, AR_PRECOND, AR_ERASE, AR_VERIFY, AR_PROGRAM, AR_BLANK
  } fes_arr_t;
  typedef enum logic [2:0] {S_NONE, S_ERASE, S_BLANK, S_WORD, S_BCNT, S_BFILL} fes_seq_t;
  typedef enum logic [1:0] {E_IDLE, E_PRE, E_ERS, E_VFY} fes_eph_t;
endpackage

// file: verilog/fes_top.sv
// command sequencer: block erase, suspend/resume, blank check
`timescale 1ns/1ps
module fes_top #(
  parameter int PRE_CYC = 1000,
  parameter int ERS_CYC = 9000000,
  parameter int VFY_CYC = 1000,
  parameter int PRG_CYC = 200,
  parameter int BC_CYC = 500,
  parameter int BUF_WORDS = 512,
  parameter int CNT_W = 24
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire fes_pkg::fes_req_t req,
  output logic [fes_pkg::DATA_W-1:0] rdata,
  input wire logic [fes_pkg::DATA_W-1:0] arr_rdata,
  input wire logic [(1<<fes_pkg::BLK_W)-1:0] blk_locked,
  input wire logic vpp_ok,
  input wire logic wp_n,
  output fes_pkg::fes_arr_t arr_cmd,
  output logic [fes_pkg::BLK_W-1:0] arr_blk
);
  localparam int NBLK = 1 << fes_pkg::BLK_W;
  localparam int NPART = 1 << fes_pkg::PART_W;
  localparam int BCW = $clog2(BUF_WORDS + 1);

  logic [fes_pkg::BLK_W-1:0] a_blk;
  logic [fes_pkg::PART_W-1:0] a_part;
  logic [15:0] cmd;
  assign a_blk = req.addr[fes_pkg::ADDR_W-1 -: fes_pkg::BLK_W];
  assign a_part = req.addr[fes_pkg::ADDR_W-1 -: fes_pkg::PART_W];
  assign cmd = req.wdata;

  // state
  fes_pkg::fes_seq_t seq;
  logic [fes_pkg::BLK_W-1:0] seq_blk;
  logic [BCW-1:0] buf_left;
  fes_pkg::fes_eph_t ers_ph;
  logic [CNT_W-1:0] ers_cnt;
  logic ers_susp;
  logic [fes_pkg::BLK_W-1:0] ers_blk;
  logic prg_busy;
  logic [CNT_W-1:0] prg_cnt;
  logic prg_susp;
  logic [fes_pkg::BLK_W-1:0] prg_blk;
  logic bc_busy;
  logic [CNT_W-1:0] bc_cnt;
  logic [fes_pkg::BLK_W-1:0] bc_blk;
  logic susp_pend;
  logic [CNT_W-1:0] susp_cnt;
  logic wp_hold;
  logic [NBLK-1:0] erased;
  fes_pkg::fes_rmode_t rmode [NPART];
  logic err_ers, err_prg, err_vpp, err_lock;
  logic [fes_pkg::PART_W-1:0] op_part;

  // derived activity
  logic ers_act, ers_run, prg_run, busy, any_susp;
  assign ers_act = ers_ph != fes_pkg::E_IDLE;
  assign ers_run = ers_act && !ers_susp;
  assign prg_run = prg_busy && !prg_susp;
  assign busy = ers_run || prg_run || bc_busy; // RQ8
  assign any_susp = ers_susp || prg_susp;

  // aborts: supply at any time, lock and protect pin while suspended
  logic ers_abort, prg_abort, ers_ab_lock, prg_ab_lock, ers_ab_vpp, prg_ab_vpp;
  assign ers_ab_vpp = ers_act && !vpp_ok; // RQ4
  assign ers_ab_lock = ers_susp && (blk_locked[ers_blk] || wp_n != wp_hold); // RQ14
  assign prg_ab_vpp = prg_busy && !vpp_ok;
  assign prg_ab_lock = prg_susp && (blk_locked[prg_blk] || wp_n != wp_hold); // RQ14
  assign ers_abort = ers_ab_vpp || ers_ab_lock;
  assign prg_abort = prg_ab_vpp || prg_ab_lock;

  // suspend takes effect once the latency has run out
  logic susp_fire;
  assign susp_fire = susp_pend && susp_cnt == '0 && (ers_run || prg_run); // RQ12

  // command decode
  logic do_ers, do_bc, do_prg, do_susp, do_res_prg, do_res_ers, do_clr;
  logic set_ers, set_prg, set_vpp, set_lock;
  logic rm_we;
  fes_pkg::fes_rmode_t rm_val;
  fes_pkg::fes_seq_t next_seq;
  logic prg_ok_now;
  logic chk_prg;

  always_comb begin
    do_ers = 1'b0;
    do_bc = 1'b0;
    do_prg = 1'b0;
    do_susp = 1'b0;
    do_res_prg = 1'b0;
    do_res_ers = 1'b0;
    do_clr = 1'b0;
    set_ers = 1'b0;
    set_prg = 1'b0;
    set_vpp = 1'b0;
    set_lock = 1'b0;
    rm_we = 1'b0;
    rm_val = fes_pkg::RM_STATUS;
    next_seq = seq;
    chk_prg = 1'b0;
    // programming is legal when idle or under erase suspend only
    prg_ok_now = !any_susp || (ers_susp && !prg_busy); // RQ16
    if (req.wr) begin
      unique case (seq)
        fes_pkg::S_ERASE: begin
          next_seq = fes_pkg::S_NONE;
          if (cmd == fes_pkg::CMD_CONFIRM) begin // RQ1
            if (blk_locked[a_blk]) begin // RQ4
              set_ers = 1'b1;
              set_lock = 1'b1;
            end else if (!vpp_ok) begin // RQ4
              set_ers = 1'b1;
              set_vpp = 1'b1;
            end else begin
              do_ers = 1'b1;
            end
          end
        end
        fes_pkg::S_BLANK: begin
          next_seq = fes_pkg::S_NONE;
          if (cmd == fes_pkg::CMD_CONFIRM && a_blk == seq_blk) begin
            do_bc = 1'b1; // RQ21
          end
        end
        fes_pkg::S_WORD: begin
          next_seq = fes_pkg::S_NONE;
          chk_prg = 1'b1;
        end
        fes_pkg::S_BCNT: begin
          next_seq = (a_blk == seq_blk) ? fes_pkg::S_BFILL : fes_pkg::S_NONE;
        end
        fes_pkg::S_BFILL: begin
          if (a_blk != seq_blk) begin
            next_seq = fes_pkg::S_NONE;
            set_prg = 1'b1;
          end else if (buf_left == '0) begin
            // any non-confirm to the buffer block drops the fill
            next_seq = fes_pkg::S_NONE;
            chk_prg = cmd == fes_pkg::CMD_CONFIRM; // RQ18
          end
        end
        default: begin
          if (bc_busy) begin
            // blank check only takes read status
            if (cmd == fes_pkg::CMD_RD_STATUS) begin // RQ22
              rm_we = 1'b1;
            end
          end else if (ers_run || prg_run) begin
            if (cmd == fes_pkg::CMD_SUSPEND) begin
              do_susp = 1'b1; // RQ11
            end else if (cmd == fes_pkg::CMD_RD_STATUS) begin
              rm_we = 1'b1; // RQ7
            end
          end else begin
            unique case (cmd)
              fes_pkg::CMD_RD_ARRAY: begin
                rm_we = 1'b1;
                rm_val = fes_pkg::RM_ARRAY;
              end
              fes_pkg::CMD_RD_STATUS: rm_we = 1'b1;
              fes_pkg::CMD_RD_ID, fes_pkg::CMD_QUERY: begin
                rm_we = 1'b1;
                rm_val = fes_pkg::RM_ID;
              end
              fes_pkg::CMD_CLR_STATUS: do_clr = 1'b1;
              fes_pkg::CMD_CONFIRM: begin
                do_res_prg = prg_susp; // RQ20
                do_res_ers = !prg_susp && ers_susp; // RQ19
              end
              fes_pkg::CMD_ERASE: begin
                if (!any_susp) begin // RQ3
                  next_seq = fes_pkg::S_ERASE;
                  rm_we = 1'b1; // RQ5
                end
              end
              fes_pkg::CMD_BLANK: begin
                if (!any_susp) begin // RQ21
                  next_seq = fes_pkg::S_BLANK;
                  rm_we = 1'b1; // RQ21
                end
              end
              fes_pkg::CMD_WORD_PROG: begin
                if (prg_ok_now) begin
                  next_seq = fes_pkg::S_WORD;
                  rm_we = 1'b1;
                end
              end
              fes_pkg::CMD_BUF_PROG: begin
                if (prg_ok_now) begin
                  next_seq = fes_pkg::S_BCNT;
                  rm_we = 1'b1;
                end
              end
              default: begin
                // factory program, suspend when idle and unknown codes are dropped
              end
            endcase
          end
        end
      endcase
      // shared checks on a program start
      if (chk_prg) begin
        if (ers_susp && a_blk == ers_blk) begin
          set_prg = 1'b1; // RQ15
        end else if (blk_locked[a_blk]) begin
          set_prg = 1'b1;
          set_lock = 1'b1;
        end else if (!vpp_ok) begin
          set_prg = 1'b1;
          set_vpp = 1'b1;
        end else begin
          do_prg = 1'b1;
        end
      end
    end
  end

  // command sequence tracking and buffer fill count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seq <= fes_pkg::S_NONE;
      seq_blk <= '0;
      buf_left <= '0;
    end else if (req.wr) begin
      seq <= next_seq;
      if (seq == fes_pkg::S_NONE) begin
        seq_blk <= a_blk;
      end
      if (seq == fes_pkg::S_BCNT) begin
        // count word holds words minus one, clipped to the buffer
        buf_left <= (cmd >= 16'(BUF_WORDS)) ? BCW'(BUF_WORDS) : BCW'(cmd + 16'h0001);
      end else if (seq == fes_pkg::S_BFILL && buf_left != '0) begin
        buf_left <= buf_left - BCW'(1);
      end
    end
  end

  // per-partition read mode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NPART; i++) begin
        rmode[i] <= fes_pkg::RM_ARRAY;
      end
    end else if (rm_we) begin
      rmode[a_part] <= rm_val; // RQ5
    end
  end

  // erase engine; reset clears it asynchronously
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ers_ph <= fes_pkg::E_IDLE; // RQ10 RQ17
      ers_cnt <= '0;
      ers_susp <= 1'b0;
      ers_blk <= '0;
    end else if (ers_abort) begin
      ers_ph <= fes_pkg::E_IDLE; // RQ4 RQ14
      ers_susp <= 1'b0;
    end else if (do_ers) begin
      ers_ph <= fes_pkg::E_PRE; // RQ6
      ers_cnt <= CNT_W'(PRE_CYC - 1);
      ers_blk <= a_blk; // RQ1
    end else if (susp_fire && !prg_run) begin
      ers_susp <= 1'b1; // RQ13
    end else if (do_res_ers) begin
      ers_susp <= 1'b0; // RQ19
    end else if (ers_run) begin
      if (ers_cnt != '0) begin
        ers_cnt <= ers_cnt - CNT_W'(1);
      end else begin
        // precondition, then erase, then verify
        unique case (ers_ph)
          fes_pkg::E_PRE: begin
            ers_ph <= fes_pkg::E_ERS; // RQ6
            ers_cnt <= CNT_W'(ERS_CYC - 1);
          end
          fes_pkg::E_ERS: begin
            ers_ph <= fes_pkg::E_VFY; // RQ6
            ers_cnt <= CNT_W'(VFY_CYC - 1);
          end
          default: ers_ph <= fes_pkg::E_IDLE;
        endcase
      end
    end
  end

  // program engine, only as far as suspend behaviour needs it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prg_busy <= 1'b0; // RQ17
      prg_cnt <= '0;
      prg_susp <= 1'b0;
      prg_blk <= '0;
    end else if (prg_abort) begin
      prg_busy <= 1'b0; // RQ14
      prg_susp <= 1'b0;
    end else if (do_prg) begin
      prg_busy <= 1'b1;
      prg_cnt <= CNT_W'(PRG_CYC - 1);
      prg_blk <= a_blk;
    end else if (susp_fire && prg_run) begin
      prg_susp <= 1'b1; // RQ13
    end else if (do_res_prg) begin
      prg_susp <= 1'b0; // RQ20
    end else if (prg_run) begin
      if (prg_cnt != '0) begin
        prg_cnt <= prg_cnt - CNT_W'(1);
      end else begin
        prg_busy <= 1'b0;
      end
    end
  end

  // blank check runner; it cannot be suspended
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bc_busy <= 1'b0;
      bc_cnt <= '0;
      bc_blk <= '0;
    end else if (do_bc) begin
      bc_busy <= 1'b1;
      bc_cnt <= CNT_W'(BC_CYC - 1);
      bc_blk <= a_blk;
    end else if (bc_busy) begin
      if (bc_cnt != '0) begin
        bc_cnt <= bc_cnt - CNT_W'(1);
      end else begin
        bc_busy <= 1'b0;
      end
    end
  end

  // suspend latency; dropped if the operation ends first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      susp_pend <= 1'b0;
      susp_cnt <= '0;
    end else if (do_susp && !susp_pend) begin
      susp_pend <= 1'b1; // RQ12
      susp_cnt <= CNT_W'(fes_pkg::SUSP_CYC - 1);
    end else if (susp_fire || !(ers_run || prg_run)) begin
      susp_pend <= 1'b0;
    end else if (susp_pend) begin
      susp_cnt <= susp_cnt - CNT_W'(1);
    end
  end

  // protect pin follows freely until something is suspended
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_hold <= 1'b0;
    end else if (!any_susp) begin
      wp_hold <= wp_n;
    end
  end

  // erased-block tracking; reset leaves every block unknown
  logic ers_done, prg_done, bc_done;
  assign ers_done = ers_run && ers_ph == fes_pkg::E_VFY && ers_cnt == '0 && !susp_fire;
  assign prg_done = prg_run && prg_cnt == '0 && !susp_fire && !prg_abort;
  assign bc_done = bc_busy && bc_cnt == '0;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      erased <= '0; // RQ10
    end else begin
      for (int i = 0; i < NBLK; i++) begin
        if (ers_done && !ers_abort && ers_blk == fes_pkg::BLK_W'(i)) begin
          erased[i] <= 1'b1; // RQ2
        end else if ((do_ers && a_blk == fes_pkg::BLK_W'(i))
                     || (prg_done && prg_blk == fes_pkg::BLK_W'(i))) begin
          erased[i] <= 1'b0;
        end
      end
    end
  end

  // sticky error bits; a new error wins over clear status
  logic bc_fail;
  assign bc_fail = bc_done && !erased[bc_blk]; // RQ22
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      err_ers <= 1'b0;
      err_prg <= 1'b0;
      err_vpp <= 1'b0;
      err_lock <= 1'b0;
    end else begin
      err_ers <= (err_ers && !do_clr) || set_ers || ers_abort || bc_fail; // RQ4 RQ22
      err_prg <= (err_prg && !do_clr) || set_prg || prg_abort; // RQ15
      err_vpp <= (err_vpp && !do_clr) || set_vpp || ers_ab_vpp || prg_ab_vpp;
      err_lock <= (err_lock && !do_clr) || set_lock || ers_ab_lock || prg_ab_lock;
    end
  end

  // partition of the operation in progress, for status bit 0
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      op_part <= '0;
    end else if (do_ers || do_bc || do_prg) begin
      op_part <= a_part;
    end
  end

  // status word as seen from the addressed partition
  logic [7:0] status;
  assign status = {!busy, ers_susp, err_ers, err_prg, err_vpp, prg_susp, err_lock,
                   (busy || any_susp) && op_part != a_part}; // RQ7 RQ13

  // read data, one cycle after the read strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
    end else if (req.rd) begin
      unique case (rmode[a_part])
        fes_pkg::RM_STATUS: rdata <= {8'h00, status}; // RQ8
        fes_pkg::RM_ID: rdata <= fes_pkg::ID_WORD;
        default: begin
          if (busy && op_part == a_part) begin
            rdata <= fes_pkg::UNDEF_WORD; // RQ9
          end else if (erased[a_blk]) begin
            rdata <= fes_pkg::ERASED_WORD; // RQ2
          end else begin
            rdata <= arr_rdata;
          end
        end
      endcase
    end else begin
      rdata <= '0;
    end
  end

  // array control: the running phase and its block
  always_comb begin
    arr_cmd = fes_pkg::AR_IDLE;
    arr_blk = '0;
    if (bc_busy) begin
      arr_cmd = fes_pkg::AR_BLANK;
      arr_blk = bc_blk;
    end else if (prg_run) begin
      arr_cmd = fes_pkg::AR_PROGRAM;
      arr_blk = prg_blk;
    end else if (ers_run) begin
      arr_blk = ers_blk;
      unique case (ers_ph)
        fes_pkg::E_PRE: arr_cmd = fes_pkg::AR_PRECOND; // RQ6
        fes_pkg::E_ERS: arr_cmd = fes_pkg::AR_ERASE;
        default: arr_cmd = fes_pkg::AR_VERIFY;
      endcase
    end
  end
endmodule

// file: dv/fes_assertions.sv
// checker: port-level properties of the erase, suspend and blank-check sequencer
`timescale 1ns/1ps
module fes_chk #(
  parameter int PRE_CYC = 1000,
  parameter int ERS_CYC = 9000000,
  parameter int VFY_CYC = 1000,
  parameter int PRG_CYC = 200,
  parameter int BC_CYC = 500,
  parameter int BUF_WORDS = 512,
  parameter int CNT_W = 24
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire fes_pkg::fes_req_t req,
  input wire logic [fes_pkg::DATA_W-1:0] rdata,
  input wire logic [fes_pkg::DATA_W-1:0] arr_rdata,
  input wire logic [(1<<fes_pkg::BLK_W)-1:0] blk_locked,
  input wire logic vpp_ok,
  input wire logic wp_n,
  input wire fes_pkg::fes_arr_t arr_cmd,
  input wire logic [fes_pkg::BLK_W-1:0] arr_blk
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // decoded requests and phases shared by the properties
  wire idle = arr_cmd == fes_pkg::AR_IDLE;
  wire is_ers = arr_cmd inside {fes_pkg::AR_PRECOND, fes_pkg::AR_ERASE, fes_pkg::AR_VERIFY};
  wire w_sus = req.wr && req.wdata == fes_pkg::CMD_SUSPEND;
  wire w_cfm = req.wr && req.wdata == fes_pkg::CMD_CONFIRM;
  wire w_ers = req.wr && req.wdata == fes_pkg::CMD_ERASE;
  wire w_blk = req.wr && req.wdata == fes_pkg::CMD_BLANK;
  wire [fes_pkg::BLK_W-1:0] ablk = req.addr[fes_pkg::ADDR_W-1:fes_pkg::OFF_W];
  logic [1:0] sus;
  int pre_n;

  // count of suspended operations: erase and program may both be parked, and a
  // resume while idle releases one at a time; blank check ignores suspend
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) sus <= 2'd0;
    else if (w_sus && !idle && arr_cmd != fes_pkg::AR_BLANK && sus != 2'd3)
      sus <= sus + 2'd1;
    else if (w_cfm && idle && sus != 2'd0) sus <= sus - 2'd1;
  end

  // cycles spent in the precondition phase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) pre_n <= 0;
    else if (arr_cmd == fes_pkg::AR_PRECOND) pre_n <= pre_n + 1;
    else pre_n <= 0;
  end

  a_erase_start: assert property (
    w_ers ##2 w_cfm && idle && !sus && vpp_ok && !blk_locked[ablk]
    |=> arr_cmd == fes_pkg::AR_PRECOND && arr_blk == $past(ablk)) else $error("erase not started");
  a_lock_refuse: assert property (
    w_ers ##2 w_cfm && idle && !sus && blk_locked[ablk] |=> idle) else $error("locked erase ran");
  a_vpp_abort: assert property (
    is_ers && !vpp_ok |-> ##[1:2] idle) else $error("erase kept running without supply");
  a_one_block: assert property (
    is_ers && $past(is_ers) |-> $stable(arr_blk)) else $error("erase block changed");
  a_phase_order: assert property (
    arr_cmd == fes_pkg::AR_ERASE && $past(arr_cmd) != fes_pkg::AR_ERASE
    && $past(arr_cmd) != fes_pkg::AR_IDLE |-> $past(arr_cmd) == fes_pkg::AR_PRECOND)
    else $error("erase phase entered out of order");
  a_precond_len: assert property (
    $past(arr_cmd) == fes_pkg::AR_PRECOND && arr_cmd == fes_pkg::AR_ERASE |-> pre_n == PRE_CYC)
    else $error("precondition length wrong");
  a_susp_halt: assert property (
    w_sus && arr_cmd == fes_pkg::AR_ERASE |=> (!idle)[*8] ##[1:200] idle)
    else $error("suspend did not halt in time");
  a_resume_go: assert property (
    w_cfm && sus && idle |-> ##[1:2] !idle) else $error("resume did not continue");
  a_blank_start: assert property (
    w_blk ##2 w_cfm && idle && !sus && ablk == $past(ablk, 2) |=> arr_cmd == fes_pkg::AR_BLANK)
    else $error("blank check not started");
  a_reset_abort: assert property (
    disable iff (1'b0) !rst_n |=> idle && rdata == '0) else $error("reset left work running");

  cover property (arr_cmd == fes_pkg::AR_VERIFY);
  cover property (w_sus && arr_cmd == fes_pkg::AR_ERASE);
  cover property (arr_cmd == fes_pkg::AR_BLANK);
endmodule

bind fes_top fes_chk #(.PRE_CYC(PRE_CYC), .ERS_CYC(ERS_CYC), .VFY_CYC(VFY_CYC),
  .PRG_CYC(PRG_CYC), .BC_CYC(BC_CYC), .BUF_WORDS(BUF_WORDS), .CNT_W(CNT_W)) i_chk (
  .clk(clk), .rst_n(rst_n), .req(req), .rdata(rdata), .arr_rdata(arr_rdata),
  .blk_locked(blk_locked), .vpp_ok(vpp_ok), .wp_n(wp_n), .arr_cmd(arr_cmd),
  .arr_blk(arr_blk));

// file: dv/fes_array_model.sv
// array stand-in: answers every address with a tagged word
`timescale 1ns/1ps
module fes_array_model (
  input wire fes_pkg::fes_req_t req,
  output logic [fes_pkg::DATA_W-1:0] arr_rdata
);
  // upper nibble 3 keeps stored words away from the erased pattern
  assign arr_rdata = {4'h3, req.addr};
endmodule

// file: dv/fes_top_tb.sv
// self-checking bench for the erase, suspend and blank-check sequencer
`timescale 1ns/1ps
module fes_top_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  fes_pkg::fes_req_t req = '0;
  logic [15:0] rdata;
  logic [15:0] arr_rdata;
  logic [31:0] blk_locked = '0;
  logic vpp_ok = 1'b1;
  logic wp_n = 1'b1;
  fes_pkg::fes_arr_t arr_cmd;
  logic [4:0] arr_blk;
  int errors = 0;
  int n_tests = 0;

  always #50 clk = ~clk;

  // erase long enough that suspend latency lands inside it
  fes_top #(.PRE_CYC(4), .ERS_CYC(400), .VFY_CYC(4), .PRG_CYC(300), .BC_CYC(8)) i_dut (
    .clk(clk), .rst_n(rst_n), .req(req), .rdata(rdata), .arr_rdata(arr_rdata),
    .blk_locked(blk_locked), .vpp_ok(vpp_ok), .wp_n(wp_n), .arr_cmd(arr_cmd),
    .arr_blk(arr_blk));
  fes_array_model i_arr (.req(req), .arr_rdata(arr_rdata));

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one-cycle strobes, released at the edge that takes them
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    req.wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [11:0] a);
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
  endtask

  task automatic st(input logic [11:0] a, input logic [7:0] e);
    rd(a);
    chk(rdata, {8'h00, e});
  endtask

  function automatic logic [11:0] ba(input logic [4:0] b);
    return {b, 7'h00};
  endfunction

  task automatic erase(input logic [4:0] b);
    wr(ba(b), fes_pkg::CMD_ERASE);
    wr(ba(b), fes_pkg::CMD_CONFIRM);
  endtask

  // poll status until ready, bounded
  task automatic wait_rdy(input logic [11:0] a);
    int i;
    for (i = 0; i < 400; i++) begin
      rd(a);
      if (rdata[7] === 1'b1) break;
    end
    if (i == 400) begin
      errors++;
      complete_run();
    end
  endtask

  task automatic wait_ph(input fes_pkg::fes_arr_t p);
    int i;
    for (i = 0; i < 1000 && arr_cmd !== p; i++) begin
      @(posedge clk);
      #1;
    end
    if (i == 1000) begin
      errors++;
      complete_run();
    end
  endtask

  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    // plain erase, status from the own and from another partition
    erase(5'd2);
    chk(arr_cmd, fes_pkg::AR_PRECOND);
    st(ba(5'd2), 8'h00);
    wr(ba(5'd5), fes_pkg::CMD_RD_STATUS);
    st(ba(5'd5), 8'h01);
    erase(5'd6);
    chk(arr_blk, 5'd2);
    wait_rdy(ba(5'd2));
    chk(rdata, 16'h0080);
    wr(ba(5'd2), fes_pkg::CMD_RD_ARRAY);
    rd(ba(5'd2) + 12'h05d);
    chk(rdata, 16'hffff);
    rd(ba(5'd1));
    chk(rdata, {4'h3, ba(5'd1)});
    // suspend, refusals, dual suspend and ordered resumes
    erase(5'd4);
    wait_ph(fes_pkg::AR_ERASE);
    wr(ba(5'd0), fes_pkg::CMD_SUSPEND);
    st(ba(5'd4), 8'h00);
    wait_rdy(ba(5'd4));
    chk(rdata, 16'h00c0);
    wr(ba(5'd4), fes_pkg::CMD_WORD_PROG);
    wr(ba(5'd4) + 12'h001, 16'h0f0f);
    st(ba(5'd4), 8'hd0);
    wr(ba(5'd4), fes_pkg::CMD_CLR_STATUS);
    st(ba(5'd4), 8'hc0);
    wr(ba(5'd5), fes_pkg::CMD_WORD_PROG);
    wr(ba(5'd5) + 12'h001, 16'h0f0f);
    chk(arr_cmd, fes_pkg::AR_PROGRAM);
    wr(ba(5'd5), fes_pkg::CMD_SUSPEND);
    wait_rdy(ba(5'd5));
    chk(rdata, 16'h00c4);
    wr(ba(5'd0), fes_pkg::CMD_CONFIRM);
    chk(arr_cmd, fes_pkg::AR_PROGRAM);
    wait_rdy(ba(5'd5));
    chk(rdata, 16'h00c0);
    // erase and blank setups are dropped, so the confirm acts as resume
    wr(ba(5'd6), fes_pkg::CMD_ERASE);
    wr(ba(5'd7), fes_pkg::CMD_BLANK);
    wr(ba(5'd7), fes_pkg::CMD_CONFIRM);
    chk(arr_cmd, fes_pkg::AR_ERASE);
    chk(arr_blk, 5'd4);
    st(ba(5'd4), 8'h00);
    wait_rdy(ba(5'd4));
    chk(rdata, 16'h0080);
    // locked block and supply loss both abort with error bits
    @(posedge clk) blk_locked[10] <= 1'b1;
    erase(5'd10);
    wait_rdy(ba(5'd10));
    chk(rdata, 16'h00a2);
    wr(ba(5'd10), fes_pkg::CMD_CLR_STATUS);
    erase(5'd11);
    wait_ph(fes_pkg::AR_ERASE);
    @(posedge clk) vpp_ok <= 1'b0;
    wait_rdy(ba(5'd11));
    chk(rdata, 16'h00a8);
    @(posedge clk) vpp_ok <= 1'b1;
    wr(ba(5'd11), fes_pkg::CMD_CLR_STATUS);
    // blank check on an erased and on a never-erased block
    wr(ba(5'd2), fes_pkg::CMD_BLANK);
    wr(ba(5'd2), fes_pkg::CMD_CONFIRM);
    chk(arr_cmd, fes_pkg::AR_BLANK);
    wr(ba(5'd0), fes_pkg::CMD_SUSPEND);
    chk(arr_cmd, fes_pkg::AR_BLANK);
    wait_rdy(ba(5'd2));
    chk(rdata, 16'h0080);
    wr(ba(5'd12), fes_pkg::CMD_BLANK);
    wr(ba(5'd12), fes_pkg::CMD_CONFIRM);
    wait_rdy(ba(5'd12));
    chk(rdata, 16'h00a0);
    // reset during a suspended erase drops it and every erased record
    erase(5'd13);
    wait_ph(fes_pkg::AR_ERASE);
    wr(ba(5'd0), fes_pkg::CMD_SUSPEND);
    wait_rdy(ba(5'd13));
    @(posedge clk) rst_n <= 1'b0;
    @(posedge clk) rst_n <= 1'b1;
    wr(ba(5'd13), fes_pkg::CMD_RD_STATUS);
    st(ba(5'd13), 8'h80);
    wr(ba(5'd2), fes_pkg::CMD_RD_ARRAY);
    rd(ba(5'd2));
    chk(rdata, {4'h3, ba(5'd2)});
    // protect pin change under erase suspend aborts with error bits
    erase(5'd14);
    wait_ph(fes_pkg::AR_ERASE);
    wr(ba(5'd0), fes_pkg::CMD_SUSPEND);
    wait_rdy(ba(5'd14));
    chk(rdata, 16'h00c0);
    @(posedge clk) wp_n <= 1'b0;
    st(ba(5'd14), 8'ha2);
    complete_run();
  end
endmodule
